/* common/mm_cfg_pkg.sv */
// Constants, modes and carriers for the memory-map configuration register bank.
// Assumes a 16-bit system address map and a 32-bit APB register bus.
package mm_cfg_pkg;

	localparam int ADDR_W = 16;
	localparam int DATA_W = 32;

	// Register indices; byte address is block base plus four times the index
	localparam logic [7:0] IDX_SYSTEM_CONTROL = 8'h13;
	localparam logic [7:0] IDX_TEST_LOCATION_A = 8'h14;
	localparam logic [7:0] IDX_TEST_LOCATION_B = 8'h17;
	localparam logic [7:0] IDX_SPACE_ALLOC_INFO_A = 8'h1C;
	localparam logic [7:0] IDX_SPACE_ALLOC_INFO_B = 8'h1D;
	localparam int IDX_TO_BYTE_SHIFT = 2;

	// Register block occupies a 2K-aligned slot in the low 32K
	localparam int BLOCK_SLOT_SHIFT = 11;
	localparam int BLOCK_POS_W = 4;

	// system_control fields
	localparam int STRETCH_LSB = 2;
	localparam int STRETCH_MSB = 3;
	localparam int UPPER_HALF_BIT = 1;
	localparam int FLASH_EN_BIT = 0;
	localparam logic [1:0] STRETCH_RESET = 2'h3;
	localparam logic UPPER_HALF_RESET = 1'b0;
	localparam logic FLASH_EN_RESET_SINGLE = 1'b1;
	localparam logic FLASH_EN_RESET_TEST = 1'b0;

	// space_alloc_info_a fields
	localparam int REG_SPACE_BIT = 7;
	localparam int EEPROM_SIZE_LSB = 4;
	localparam int RAM_SIZE_LSB = 0;
	// space_alloc_info_b fields
	localparam int FLASH_SIZE_LSB = 6;
	localparam int PAGING_LSB = 0;

	// RAM allocation unit and position field
	localparam int RAM_UNIT_SHIFT = 11;
	localparam int RAM_POS_W = 5;

	typedef enum logic [2:0]
	{
		MM_MODE_SPECIAL_SINGLE = 3'h0,
		MM_MODE_SPECIAL_EXPANDED = 3'h1,
		MM_MODE_SPECIAL_PERIPHERAL = 3'h2,
		MM_MODE_SPECIAL_TEST = 3'h3,
		MM_MODE_NORMAL_SINGLE = 3'h4,
		MM_MODE_NORMAL_EXPANDED = 3'h5,
		MM_MODE_EMULATION_SINGLE = 3'h6,
		MM_MODE_EMULATION_EXPANDED = 3'h7
	} mm_mode_t;

	typedef enum logic [1:0]
	{
		MM_ST_SYNC = 2'h0,
		MM_ST_LOAD = 2'h1,
		MM_ST_RUN = 2'h3
	} mm_state_t;

	typedef struct packed
	{
		logic register_space_size_bit;
		logic [1:0] eeprom_size_field;
		logic [2:0] ram_size_field;
		logic [1:0] flash_size_field;
		logic [1:0] paging_split_field;
	} mm_switches_t;

	typedef struct packed
	{
		logic [1:0] external_stretch_field;
		logic upper_half_only_flag;
		logic flash_enable_flag;
	} mm_control_t;

endpackage : mm_cfg_pkg

/* verilog/mm_cfg_regs.sv */
// Memory-map configuration register bank: system control, two test
// locations and two read-only space allocation registers, on APB.
// Assumes mode and integration switches arrive asynchronously as pins, and
// the register block and RAM position values come from logic on pclk.
//
// Functional notes
// - Registers sit at offsets above the relocatable register block base.
// - A system control write affects outputs one clock after the write.
// - Stretch field adds zero to three clocks to each external access.
// - Stretch has no effect in single-chip and peripheral modes.
// - Control fields write once in normal/emulation, anytime in special modes.
// - Upper-half-only flag blocks direct access to low-half flash pages.
// - Flash enable flag removes or places flash in the map.
// - Reset: stretch 11, upper-half 0, flash enable by mode.
// - Test locations readable anytime; writes change nothing.
// - Size registers ignore writes and read integration inputs.
// - First size register shows register, EEPROM and RAM switches.
// - Register space bit reads 0 for 1K, 1 for 2K.
// - EEPROM field encodes 0K, 2K, 4K, 8K.
// - RAM field encodes 2K to 16K in 2K steps.
// - RAM code sets region, position bits used and base address.
// - RAM smaller than region is aligned by the high-align bit.
// - High-align 0 aligns low, 1 aligns to region top.
// - Second size register shows flash size and paging switches.
// - Flash size field encodes 0K, 16K, 48K, 64K.
// - Paging field encodes the off-chip/on-chip split.
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps

module mm_cfg_regs
#(
	parameter logic FLASH_EN_RESET_EXPANDED = 1'b0,
	parameter logic [7:0] TEST_A_VALUE = 8'h00,
	parameter logic [7:0] TEST_B_VALUE = 8'h00
)
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [mm_cfg_pkg::ADDR_W-1:0] paddr,
	input wire logic [mm_cfg_pkg::DATA_W-1:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [mm_cfg_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	// Asynchronous mode and integration switches
	input wire logic [2:0] mode_pins,
	input wire mm_cfg_pkg::mm_switches_t switch_pins,
	// Position settings from neighbouring logic on pclk
	input wire logic [mm_cfg_pkg::BLOCK_POS_W-1:0] register_block_position,
	input wire logic [mm_cfg_pkg::RAM_POS_W-1:0] ram_position,
	input wire logic ram_high_align_bit,
	// Map control outputs
	output logic [1:0] stretch_cycles,
	output logic flash_in_map,
	output logic flash_low_half_direct,
	output logic [mm_cfg_pkg::ADDR_W-1:0] ram_base_addr,
	output logic [mm_cfg_pkg::ADDR_W:0] ram_alloc_bytes
);

	mm_cfg_pkg::mm_state_t state_reg;
	mm_cfg_pkg::mm_state_t state_next;
	logic sync_wait_reg;
	logic settled_reg;
	logic [2:0] mode_meta_reg;
	logic [2:0] mode_sync_reg;
	mm_cfg_pkg::mm_switches_t sw_meta_reg;
	mm_cfg_pkg::mm_switches_t sw_sync_reg;
	mm_cfg_pkg::mm_control_t ctrl_reg;
	logic ctrl_written_reg;
	logic [mm_cfg_pkg::DATA_W-1:0] prdata_reg;
	logic pslverr_reg;
	mm_cfg_pkg::mm_mode_t mode;
	logic mode_special;
	logic mode_stretch_ok;
	logic access;
	logic hit_ctrl;
	logic hit_test_a;
	logic hit_test_b;
	logic hit_info_a;
	logic hit_info_b;
	logic hit_any;
	logic ctrl_write;
	logic [7:0] info_a;
	logic [7:0] info_b;
	logic [7:0] ctrl_read;
	logic [7:0] read_byte;

	// Address match for one register index inside the relocatable block
	function automatic logic reg_hit
	(
		input logic [mm_cfg_pkg::ADDR_W-1:0] addr,
		input logic [mm_cfg_pkg::BLOCK_POS_W-1:0] pos,
		input logic [7:0] idx
	);
		logic [mm_cfg_pkg::ADDR_W-1:0] base;
		logic [mm_cfg_pkg::ADDR_W-1:0] target;
		base = mm_cfg_pkg::ADDR_W'({pos, mm_cfg_pkg::BLOCK_SLOT_SHIFT'(0)});
		target = base + (mm_cfg_pkg::ADDR_W'(idx) << mm_cfg_pkg::IDX_TO_BYTE_SHIFT);
		reg_hit = (addr == target);
	endfunction : reg_hit

	// Region size in bytes for a RAM size code
	function automatic logic [mm_cfg_pkg::ADDR_W:0] ram_region
	(
		input logic [2:0] code
	);
		logic [mm_cfg_pkg::ADDR_W:0] unit;
		unit = (mm_cfg_pkg::ADDR_W+1)'(1) << mm_cfg_pkg::RAM_UNIT_SHIFT;
		if (code == 3'h0)
		begin
			ram_region = unit;
		end
		else if (code == 3'h1)
		begin
			ram_region = unit << 1;
		end
		else if (code[2] == 1'b0)
		begin
			ram_region = unit << 2;
		end
		else
		begin
			ram_region = unit << 3;
		end
	endfunction : ram_region

	// Two-flop synchronisers for mode and integration switches
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mode_meta_reg <= 3'h0;
			mode_sync_reg <= 3'h0;
			sw_meta_reg <= '0;
			sw_sync_reg <= '0;
		end
		else
		begin
			mode_meta_reg <= mode_pins;
			mode_sync_reg <= mode_meta_reg;
			sw_meta_reg <= switch_pins;
			sw_sync_reg <= sw_meta_reg;
		end
	end

	assign mode = mm_cfg_pkg::mm_mode_t'(mode_sync_reg);
	assign mode_special = (mode_sync_reg[2] == 1'b0);

	always_comb
	begin
		case (mode)
			mm_cfg_pkg::MM_MODE_SPECIAL_EXPANDED,
			mm_cfg_pkg::MM_MODE_NORMAL_EXPANDED,
			mm_cfg_pkg::MM_MODE_EMULATION_EXPANDED:
			begin
				mode_stretch_ok = 1'b1;
			end
			default:
			begin
				mode_stretch_ok = 1'b0;
			end
		endcase
	end

	// Start-up: wait for synchronised straps, load mode-dependent reset values, then serve the bus
	always_comb
	begin
		case (state_reg)
			mm_cfg_pkg::MM_ST_SYNC:
			begin
				state_next = sync_wait_reg ? mm_cfg_pkg::MM_ST_LOAD : mm_cfg_pkg::MM_ST_SYNC;
			end
			mm_cfg_pkg::MM_ST_LOAD:
			begin
				state_next = mm_cfg_pkg::MM_ST_RUN;
			end
			default:
			begin
				state_next = mm_cfg_pkg::MM_ST_RUN;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_reg <= mm_cfg_pkg::MM_ST_SYNC;
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	// Straps need two edges out of reset to cross the synchroniser before the load;
	// the bus waits one edge after the load so a captured read never predates it
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sync_wait_reg <= 1'b0;
			settled_reg <= 1'b0;
		end
		else
		begin
			sync_wait_reg <= (state_reg == mm_cfg_pkg::MM_ST_SYNC);
			settled_reg <= (state_reg == mm_cfg_pkg::MM_ST_RUN);
		end
	end

	// Bus decode
	assign access = psel && penable && pready;
	assign hit_ctrl = reg_hit(paddr, register_block_position, mm_cfg_pkg::IDX_SYSTEM_CONTROL);
	assign hit_test_a = reg_hit(paddr, register_block_position, mm_cfg_pkg::IDX_TEST_LOCATION_A);
	assign hit_test_b = reg_hit(paddr, register_block_position, mm_cfg_pkg::IDX_TEST_LOCATION_B);
	assign hit_info_a = reg_hit(paddr, register_block_position, mm_cfg_pkg::IDX_SPACE_ALLOC_INFO_A);
	assign hit_info_b = reg_hit(paddr, register_block_position, mm_cfg_pkg::IDX_SPACE_ALLOC_INFO_B);
	assign hit_any = hit_ctrl || hit_test_a || hit_test_b || hit_info_a || hit_info_b;
	assign ctrl_write = access && pwrite && hit_ctrl && pstrb[0] && (mode_special || !ctrl_written_reg);

	// System control register; mode-dependent flash enable loaded once straps are stable
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_reg.external_stretch_field <= mm_cfg_pkg::STRETCH_RESET;
			ctrl_reg.upper_half_only_flag <= mm_cfg_pkg::UPPER_HALF_RESET;
			ctrl_reg.flash_enable_flag <= mm_cfg_pkg::FLASH_EN_RESET_TEST;
		end
		else if (state_reg == mm_cfg_pkg::MM_ST_LOAD)
		begin
			if (mode == mm_cfg_pkg::MM_MODE_SPECIAL_TEST)
			begin
				ctrl_reg.flash_enable_flag <= mm_cfg_pkg::FLASH_EN_RESET_TEST;
			end
			else if (mode_stretch_ok || mode == mm_cfg_pkg::MM_MODE_EMULATION_SINGLE)
			begin
				ctrl_reg.flash_enable_flag <= FLASH_EN_RESET_EXPANDED;
			end
			else
			begin
				ctrl_reg.flash_enable_flag <= mm_cfg_pkg::FLASH_EN_RESET_SINGLE;
			end
		end
		else if (ctrl_write)
		begin
			ctrl_reg.external_stretch_field <= pwdata[mm_cfg_pkg::STRETCH_MSB:mm_cfg_pkg::STRETCH_LSB];
			ctrl_reg.upper_half_only_flag <= pwdata[mm_cfg_pkg::UPPER_HALF_BIT];
			ctrl_reg.flash_enable_flag <= pwdata[mm_cfg_pkg::FLASH_EN_BIT];
		end
	end

	// Write-once lock, ignored in special modes
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_written_reg <= 1'b0;
		end
		else if (ctrl_write)
		begin
			ctrl_written_reg <= 1'b1;
		end
	end

	// Read data assembly
	always_comb
	begin
		ctrl_read = 8'h00;
		ctrl_read[mm_cfg_pkg::STRETCH_MSB:mm_cfg_pkg::STRETCH_LSB] = ctrl_reg.external_stretch_field;
		ctrl_read[mm_cfg_pkg::UPPER_HALF_BIT] = ctrl_reg.upper_half_only_flag;
		ctrl_read[mm_cfg_pkg::FLASH_EN_BIT] = ctrl_reg.flash_enable_flag;
		info_a = 8'h00;
		info_a[mm_cfg_pkg::REG_SPACE_BIT] = sw_sync_reg.register_space_size_bit;
		info_a[mm_cfg_pkg::EEPROM_SIZE_LSB +: 2] = sw_sync_reg.eeprom_size_field;
		info_a[mm_cfg_pkg::RAM_SIZE_LSB +: 3] = sw_sync_reg.ram_size_field;
		info_b = 8'h00;
		info_b[mm_cfg_pkg::FLASH_SIZE_LSB +: 2] = sw_sync_reg.flash_size_field;
		info_b[mm_cfg_pkg::PAGING_LSB +: 2] = sw_sync_reg.paging_split_field;
		if (hit_ctrl)
		begin
			read_byte = ctrl_read;
		end
		else if (hit_test_a)
		begin
			read_byte = TEST_A_VALUE;
		end
		else if (hit_test_b)
		begin
			read_byte = TEST_B_VALUE;
		end
		else if (hit_info_a)
		begin
			read_byte = info_a;
		end
		else if (hit_info_b)
		begin
			read_byte = info_b;
		end
		else
		begin
			read_byte = 8'h00;
		end
	end

	// Registered APB answer; writes to read-only locations are dropped without error
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata_reg <= '0;
			pslverr_reg <= 1'b0;
		end
		else if (psel && !(penable && pready))
		begin
			// Refreshed until the access completes, so a setup made during start-up reads loaded values
			prdata_reg <= {24'h000000, read_byte};
			pslverr_reg <= !hit_any;
		end
	end

	assign pready = (state_reg == mm_cfg_pkg::MM_ST_RUN) && settled_reg;
	assign prdata = (access && !pwrite) ? prdata_reg : '0;
	assign pslverr = access && pslverr_reg;

	// Map control outputs
	assign stretch_cycles = mode_stretch_ok ? ctrl_reg.external_stretch_field : 2'h0;
	assign flash_in_map = ctrl_reg.flash_enable_flag;
	assign flash_low_half_direct = ctrl_reg.flash_enable_flag && !ctrl_reg.upper_half_only_flag;

	// RAM placement from size code, position and alignment
	always_comb
	begin
		logic [mm_cfg_pkg::ADDR_W:0] region;
		logic [mm_cfg_pkg::ADDR_W:0] alloc;
		logic [mm_cfg_pkg::ADDR_W:0] mask;
		logic [mm_cfg_pkg::ADDR_W:0] pos_addr;
		region = ram_region(sw_sync_reg.ram_size_field);
		alloc = (mm_cfg_pkg::ADDR_W+1)'({1'b0, sw_sync_reg.ram_size_field} + 4'h1) << mm_cfg_pkg::RAM_UNIT_SHIFT;
		mask = ~(region - (mm_cfg_pkg::ADDR_W+1)'(1));
		pos_addr = (mm_cfg_pkg::ADDR_W+1)'({ram_position, mm_cfg_pkg::RAM_UNIT_SHIFT'(0)}) & mask;
		if (ram_high_align_bit)
		begin
			pos_addr = pos_addr + (region - alloc);
		end
		ram_base_addr = pos_addr[mm_cfg_pkg::ADDR_W-1:0];
		ram_alloc_bytes = alloc;
	end

endmodule : mm_cfg_regs

/* tb/mm_cfg_regs_properties.sv */
// Port-level checks for the memory-map configuration bank.
// Assumes an APB master that holds each request until pready.
`timescale 1ns/1ps
module mm_cfg_props
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [15:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Straps and map outputs
	input wire logic [2:0] mode_pins,
	input wire mm_cfg_pkg::mm_switches_t switch_pins,
	input wire logic [3:0] register_block_position,
	input wire logic [1:0] stretch_cycles,
	input wire logic flash_in_map,
	input wire logic flash_low_half_direct
);
	logic [15:0] base;
	logic acc;
	logic [3:0] wd_q;
	assign base = {1'b0, register_block_position, 11'h000};
	assign acc = psel && penable && pready;
	always_ff @(posedge pclk) wd_q <= pwdata[3:0];
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_ready_holds: assert property (pready |=> pready) else $error("pready dropped");
	a_upper_zero: assert property (prdata[31:8] == 24'h0) else $error("upper read bits set");
	a_no_stretch: assert property (
		(mode_pins != 3'h1 && mode_pins != 3'h5 && mode_pins != 3'h7) [*3] |-> stretch_cycles == 2'h0)
		else $error("stretch outside expanded mode");
	a_ctrl_write: assert property (
		(mode_pins == 3'h1) [*3] ##0 (acc && pwrite && pstrb[0] && paddr == base + 16'h004C)
		|=> stretch_cycles == wd_q[3:2] && flash_in_map == wd_q[0]
		&& flash_low_half_direct == (wd_q[0] && !wd_q[1])) else $error("control write lost");
	a_flash_hold: assert property (pready && !(acc && pwrite) |=> $stable(flash_in_map))
		else $error("flash flag moved");
	a_low_half: assert property (
		acc && !pwrite && paddr == base + 16'h004C
		|-> flash_in_map == prdata[0] && flash_low_half_direct == (prdata[0] && !prdata[1]))
		else $error("map outputs differ from control readback");
	a_err_hole: assert property (
		acc |-> pslverr == (paddr != base + 16'h004C && paddr != base + 16'h0050 && paddr != base + 16'h005C
		&& paddr != base + 16'h0070 && paddr != base + 16'h0074)) else $error("error flag wrong for address");
	a_info_read: assert property (
		$stable(switch_pins) [*4] ##0 (acc && !pwrite && paddr == base + 16'h0074)
		|-> prdata[7:0] == {switch_pins.flash_size_field, 4'h0, switch_pins.paging_split_field})
		else $error("size info wrong");
endmodule : mm_cfg_props

bind mm_cfg_regs mm_cfg_props u_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
	.prdata, .pready, .pslverr, .mode_pins, .switch_pins, .register_block_position, .stretch_cycles,
	.flash_in_map, .flash_low_half_direct);

/* tb/mm_apb_master.sv */
// APB master standing in for the CPU core on the register bus.
// Assumes one transfer at a time, called from the bench.
`timescale 1ns/1ps
module mm_apb_master
(
	// Clock
	input wire logic pclk,
	// Request
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [15:0] paddr,
	output logic [31:0] pwdata,
	output logic [3:0] pstrb,
	// Answer
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	initial
	begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 16'h0000;
		pwdata = 32'h0;
		pstrb = 4'h0;
	end

	task xfer(input logic w, input logic [15:0] a, input logic [31:0] d, input logic [3:0] s,
		output logic [31:0] r, output logic e);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Idle data must not look like the last value
		pwdata <= ~d;
	endtask : xfer
endmodule : mm_apb_master

/* tb/tb_memory_map_config_regs.sv */
// Self-checking bench for the memory-map configuration bank.
// Assumes the APB master model and the bound checker.
`timescale 1ns/1ps
module tb_memory_map_config_regs;
	logic pclk;
	logic presetn;
	logic [2:0] mode_pins;
	mm_cfg_pkg::mm_switches_t switch_pins;
	logic [3:0] register_block_position;
	logic [4:0] ram_position;
	logic ram_high_align_bit;
	logic psel, penable, pwrite, pready, pslverr, er;
	logic [15:0] paddr, ram_base_addr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] pstrb;
	logic [1:0] stretch_cycles;
	logic flash_in_map, flash_low_half_direct;
	logic [16:0] ram_alloc_bytes;
	int error_cnt = 0;
	int cmp_count = 0;

	mm_apb_master u_m (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr);
	mm_cfg_regs u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
		.pslverr, .mode_pins, .switch_pins, .register_block_position, .ram_position, .ram_high_align_bit,
		.stretch_cycles, .flash_in_map, .flash_low_half_direct, .ram_base_addr, .ram_alloc_bytes);

	initial
	begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end

	task chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task xr(input logic [7:0] i);
		u_m.xfer(1'b0, {1'b0, register_block_position, 11'h000} + {6'h00, i, 2'b00}, 32'h0, 4'hF, rd, er);
	endtask : xr

	task xw(input logic [7:0] i, input logic [7:0] d, input logic [3:0] s);
		u_m.xfer(1'b1, {1'b0, register_block_position, 11'h000} + {6'h00, i, 2'b00}, {24'h0, d}, s, rd, er);
	endtask : xw

	task do_reset(input logic [2:0] m);
		@(posedge pclk);
		presetn <= 1'b0;
		mode_pins <= m;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		repeat (3) @(posedge pclk);
	endtask : do_reset

	task t_modes;
		for (int k = 0; k < 8; k++)
		begin
			do_reset(k[2:0]);
			xr(8'h13);
			chk(rd, (k == 0 || k == 2 || k == 4) ? 32'h0D : 32'h0C);
			chk(stretch_cycles, (k == 1 || k == 5 || k == 7) ? 2'h3 : 2'h0);
		end
		$display("done t_modes");
	endtask : t_modes

	task t_once;
		do_reset(3'h4);
		xw(8'h13, 8'hF6, 4'hE);
		xr(8'h13);
		chk(rd, 32'h0D);
		xw(8'h13, 8'hF6, 4'hF);
		xr(8'h13);
		chk(rd, 32'h06);
		chk(flash_in_map, 1'b0);
		xw(8'h13, 8'h0D, 4'hF);
		xr(8'h13);
		chk(rd, 32'h06);
		$display("done t_once");
	endtask : t_once

	task t_special;
		do_reset(3'h1);
		for (int k = 0; k < 8; k++)
		begin
			xw(8'h13, {4'hA, k[1:0], k[2], 1'b1}, 4'hF);
			@(negedge pclk);
			chk(stretch_cycles, k[1:0]);
			chk(flash_low_half_direct, !k[2]);
		end
		$display("done t_special");
	endtask : t_special

	task t_readonly;
		logic [7:0] ix [4];
		logic [7:0] ev [4];
		ix = '{8'h1C, 8'h1D, 8'h14, 8'h17};
		ev = '{8'hA4, 8'hC1, 8'h00, 8'h00};
		do_reset(3'h0);
		switch_pins <= 10'h34D;
		ram_position <= 5'h01;
		ram_high_align_bit <= 1'b1;
		register_block_position <= 4'h5;
		repeat (4) @(posedge pclk);
		for (int j = 0; j < 4; j++)
		begin
			xw(ix[j], 8'hFF, 4'hF);
			xr(ix[j]);
			chk(rd, {24'h0, ev[j]});
		end
		xr(8'h15);
		chk(er, 1'b1);
		chk(ram_base_addr, 16'h1800);
		chk(ram_alloc_bytes, 17'h02800);
		ram_high_align_bit <= 1'b0;
		repeat (2) @(posedge pclk);
		chk(ram_base_addr, 16'h0000);
		switch_pins.ram_size_field <= 3'h0;
		repeat (4) @(posedge pclk);
		chk(ram_base_addr, 16'h0800);
		switch_pins.ram_size_field <= 3'h2;
		ram_high_align_bit <= 1'b1;
		repeat (4) @(posedge pclk);
		chk(ram_base_addr, 16'h0800);
		switch_pins.ram_size_field <= 3'h5;
		repeat (4) @(posedge pclk);
		chk(ram_base_addr, 16'h1000);
		chk(ram_alloc_bytes, 17'h03000);
		$display("done t_readonly");
	endtask : t_readonly

	task tally_and_finish;
		$display("compares=%0d mismatches=%0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : tally_and_finish

	initial
	begin
		presetn = 1'b0;
		mode_pins = 3'h4;
		switch_pins = 10'h000;
		register_block_position = 4'h0;
		ram_position = 5'h00;
		ram_high_align_bit = 1'b0;
		t_modes;
		t_once;
		t_special;
		t_readonly;
		tally_and_finish;
	end

	initial
	begin
		repeat (20000) @(posedge pclk);
		error_cnt++;
		tally_and_finish;
	end
endmodule : tb_memory_map_config_regs
